// [design/nsp_ctrl.sv]
// What this block does
// - Memory select one routes to program flash, zero to data EEPROM.
// - Config select one targets config, user ID and device ID space.
// - Latch-only set in flash/config: write only loads the addressed latch.
// - Latch-only clear: load latch then program whole latch row in flash, only the addressed user ID word in config.
// - Data EEPROM ignores latch-only; every write starts an EEPROM write.
// - Erase field makes next flash write an erase; cleared on completion.
// - Data EEPROM ignores erase field; erase then write each time.
// - Error flag set on bad sequence or any write-bit set; zero after good end.
// - Program enable zero inhibits all programming and erasing.
// - Write bit starts a timed operation; hardware clears; software zero ignored.
// - Read bit fetches word into data pair in one cycle, then self clears.
// - Unlock register is write-only, stores nothing, feeds key checker only.
// - Low data register holds eight read/write bits.
// - High data register holds six bits; upper two read zero.
// - Low address register gives eight address bits, resets to zero.
// - High address register gives seven bits; top bit reads zero.
// - Config space: user IDs read/write, device ID and config words read only.
// - Config read outside accessible ranges clears both data registers.
// - Processor stalls during flash program or erase; next instruction ignored.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module nsp_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_stall,
  output logic nvm_done_pulse
);
  import nsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: small arrays stand in for the memories
  logic [7:0] eeprom_mem [0:255];
  logic [13:0] flash_mem [0:255];
  logic [13:0] latch_mem [0:7];
  logic [13:0] uid_mem [0:3];

  logic [7:0] data_low_ff, nxt_data_low;
  logic [5:0] data_high_ff, nxt_data_high;
  logic [7:0] addr_low_ff;
  logic [6:0] addr_high_ff;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic key_armed_ff, nxt_key_armed;
  logic unlocked_ff, nxt_unlocked;
  logic event_ff, nxt_event;
  logic [7:0] timer_ff, nxt_timer;
  logic is_erase_ff, is_row_ff, is_eep_ff;
  nsp_state_e state_ff, nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel: take address and data in either order
  logic [4:0] aw_ff;
  logic aw_have_ff, w_have_ff, bvalid_ff;
  logic [31:0] w_ff;
  logic [3:0] strb_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // A register write fires once both halves are held
  wire wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
  wire wr_lane0 = wr_go && strb_ff[0];
  wire [7:0] wbyte = w_ff[7:0];
  wire wr_dlow = wr_lane0 && aw_ff == NSP_OFS_DATA_LOW;
  wire wr_dhigh = wr_lane0 && aw_ff == NSP_OFS_DATA_HIGH;
  wire wr_alow = wr_lane0 && aw_ff == NSP_OFS_ADDR_LOW;
  wire wr_ahigh = wr_lane0 && aw_ff == NSP_OFS_ADDR_HIGH;
  wire wr_ctrl = wr_lane0 && aw_ff == NSP_OFS_CONTROL;
  wire wr_key = wr_lane0 && aw_ff == NSP_OFS_UNLOCK;
  wire wr_evt = wr_lane0 && aw_ff == NSP_OFS_EVENT;
  wire wr_mapped = aw_ff <= NSP_OFS_EVENT && aw_ff[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      aw_ff <= 5'h00;
      w_ff <= 32'h0000_0000;
      strb_ff <= 4'h0;
      bresp_ff <= NSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        w_ff <= s_axi_wdata;
        strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? NSP_RESP_OKAY : NSP_RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target decode
  wire mem_sel = ctrl_ff[NSP_BIT_MEMSEL];
  wire cfg_sel = ctrl_ff[NSP_BIT_CFGSEL];
  wire eep_sel = !cfg_sel && !mem_sel;
  wire [14:0] loc = {addr_high_ff, addr_low_ff};
  wire cfg_uid = loc >= NSP_CFG_UID_LO && loc <= NSP_CFG_UID_HI;
  wire cfg_dev = loc == NSP_CFG_DEVID;
  wire cfg_word = loc >= NSP_CFG_WORD_LO && loc <= NSP_CFG_WORD_HI;
  wire [13:0] nvm_word = {data_high_ff, data_low_ff};

  // Read data for the read bit, chosen by target
  logic [13:0] fetch_word;
  always_comb begin
    fetch_word = 14'h0000;
    if (cfg_sel) begin
      if (cfg_uid) fetch_word = uid_mem[loc[1:0]];
      else if (cfg_dev) fetch_word = NSP_DEVICE_ID;
      else if (cfg_word) fetch_word = 14'h3fff;
      else fetch_word = 14'h0000;
    end else if (mem_sel) begin
      fetch_word = flash_mem[addr_low_ff];
    end else begin
      fetch_word = {6'h00, eeprom_mem[addr_low_ff]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control: write bit set attempt, gated by unlock and enable
  wire set_wr = wr_ctrl && wbyte[NSP_BIT_WRITE] && !ctrl_ff[NSP_BIT_WRITE];
  wire wr_ok = set_wr && unlocked_ff && ctrl_ff[NSP_BIT_PGMEN] &&
               wbyte[NSP_BIT_PGMEN];
  wire cfg_ro = cfg_sel && !cfg_uid;
  wire start_op = wr_ok && state_ff == NSP_IDLE && !cfg_ro;
  wire latch_only = !eep_sel && ctrl_ff[NSP_BIT_LATCH];
  wire finish = state_ff == NSP_BUSY && timer_ff == 8'h01;
  wire set_rd = wr_ctrl && wbyte[NSP_BIT_READ];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_data_low = data_low_ff;
    nxt_data_high = data_high_ff;
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_event = event_ff;
    if (wr_dlow) nxt_data_low = wbyte;
    if (wr_dhigh) nxt_data_high = wbyte[5:0];
    if (wr_ctrl) begin
      // Write and read bits can only be set; error bit can only be cleared
      nxt_ctrl[7:2] = wbyte[7:2];
      nxt_ctrl[NSP_BIT_ERR] = ctrl_ff[NSP_BIT_ERR] && wbyte[NSP_BIT_ERR];
    end
    if (ctrl_ff[NSP_BIT_READ]) begin
      nxt_ctrl[NSP_BIT_READ] = 1'b0;
      nxt_data_low = fetch_word[7:0];
      nxt_data_high = fetch_word[13:8];
    end else if (set_rd) begin
      nxt_ctrl[NSP_BIT_READ] = 1'b1;
    end
    if (set_wr) nxt_ctrl[NSP_BIT_ERR] = 1'b1;
    if (start_op && latch_only) begin
      nxt_ctrl[NSP_BIT_ERR] = 1'b0;
    end else if (start_op) begin
      nxt_ctrl[NSP_BIT_WRITE] = 1'b1;
      nxt_state = NSP_BUSY;
      nxt_timer = NSP_PROG_CYC;
    end
    if (event_ff && wr_evt && wbyte[0]) nxt_event = 1'b0;
    if (state_ff == NSP_BUSY) begin
      nxt_timer = timer_ff - 8'h01;
      if (finish) begin
        nxt_state = NSP_IDLE;
        nxt_ctrl[NSP_BIT_WRITE] = 1'b0;
        nxt_ctrl[NSP_BIT_ERR] = 1'b0;
        if (is_erase_ff) nxt_ctrl[NSP_BIT_ERASE] = 1'b0;
        nxt_event = 1'b1;
      end
    end
  end

  // Unlock key checker: nothing stored but sequence progress
  always_comb begin
    nxt_key_armed = key_armed_ff;
    nxt_unlocked = unlocked_ff;
    if (wr_go) begin
      nxt_key_armed = wr_key && wbyte == NSP_KEY_FIRST;
      nxt_unlocked = key_armed_ff && wr_key && wbyte == NSP_KEY_SECOND;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_low_ff <= NSP_RST_BYTE;
      data_high_ff <= NSP_RST_HIGH6;
      addr_low_ff <= NSP_RST_BYTE;
      addr_high_ff <= NSP_RST_ADDR7;
      ctrl_ff <= NSP_RST_BYTE;
      key_armed_ff <= 1'b0;
      unlocked_ff <= 1'b0;
      event_ff <= 1'b0;
      timer_ff <= 8'h00;
      state_ff <= NSP_IDLE;
    end else begin
      data_low_ff <= nxt_data_low;
      data_high_ff <= nxt_data_high;
      if (wr_alow) addr_low_ff <= wbyte;
      if (wr_ahigh) addr_high_ff <= wbyte[6:0];
      ctrl_ff <= nxt_ctrl;
      key_armed_ff <= nxt_key_armed;
      unlocked_ff <= nxt_unlocked;
      event_ff <= nxt_event;
      timer_ff <= nxt_timer;
      state_ff <= nxt_state;
    end
  end

  // Operation kind captured at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      is_erase_ff <= 1'b0;
      is_row_ff <= 1'b0;
      is_eep_ff <= 1'b0;
    end else if (start_op) begin
      is_erase_ff <= !eep_sel && ctrl_ff[NSP_BIT_ERASE];
      is_row_ff <= !eep_sel && !ctrl_ff[NSP_BIT_LATCH];
      is_eep_ff <= eep_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory arrays: latches load at start, row commits at finish
  always_ff @(posedge aclk) begin
    if (start_op && !eep_sel && !ctrl_ff[NSP_BIT_ERASE]) begin
      latch_mem[addr_low_ff[2:0]] <= nvm_word;
    end
    if (finish && is_eep_ff) begin
      eeprom_mem[addr_low_ff] <= data_low_ff;
    end
    if (finish && !is_eep_ff && cfg_sel && is_row_ff && !is_erase_ff) begin
      uid_mem[loc[1:0]] <= latch_mem[loc[2:0]];
    end
    for (int i = 0; i < 8; i++) begin
      if (finish && !is_eep_ff && !cfg_sel && (is_row_ff || is_erase_ff)) begin
        flash_mem[{addr_low_ff[7:3], 3'(i)}] <=
          is_erase_ff ? 14'h3fff : latch_mem[i];
      end
    end
  end

  // Processor stall while a flash or config operation is timed
  assign cpu_stall = state_ff == NSP_BUSY && !is_eep_ff;
  assign nvm_done_pulse = finish;

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      NSP_OFS_DATA_LOW: rd_byte = data_low_ff;
      NSP_OFS_DATA_HIGH: rd_byte = {2'b00, data_high_ff};
      NSP_OFS_ADDR_LOW: rd_byte = addr_low_ff;
      NSP_OFS_ADDR_HIGH: rd_byte = {1'b0, addr_high_ff};
      NSP_OFS_CONTROL: rd_byte = ctrl_ff;
      NSP_OFS_EVENT: rd_byte = {7'h00, event_ff};
      default: rd_byte = 8'h00;
    endcase
  end
  wire rd_mapped = s_axi_araddr <= NSP_OFS_EVENT && s_axi_araddr[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= NSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_mapped ? NSP_RESP_OKAY : NSP_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff[NSP_BIT_READ] |=> !ctrl_ff[NSP_BIT_READ])
    else $error("read bit did not clear");
  a_read_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff[NSP_BIT_READ] |=> {data_high_ff, data_low_ff} == $past(fetch_word))
    else $error("read did not load data pair");
  a_cfg_bad_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff[NSP_BIT_READ] && cfg_sel && !cfg_uid && !cfg_dev && !cfg_word
    |=> data_low_ff == 8'h00 && data_high_ff == 6'h00)
    else $error("unmapped config read left data");
  a_no_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff[NSP_BIT_PGMEN] && state_ff == NSP_IDLE |=> state_ff == NSP_IDLE)
    else $error("operation started without enable");
  a_key_needed: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !wr_key |=> !unlocked_ff && !key_armed_ff)
    else $error("key progress kept across another write");
  a_err_on_set: assert property (@(posedge aclk) disable iff (!aresetn)
    set_wr && !start_op |=> ctrl_ff[NSP_BIT_ERR])
    else $error("error flag not set");
  a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    finish |=> !ctrl_ff[NSP_BIT_WRITE] && !ctrl_ff[NSP_BIT_ERR] && event_ff)
    else $error("completion did not clear write");
  a_stall_flash: assert property (@(posedge aclk) disable iff (!aresetn)
    start_op && !eep_sel && !latch_only |=> cpu_stall [*8])
    else $error("processor not stalled");
  a_addr_top: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_araddr) == NSP_OFS_ADDR_HIGH && $past(s_axi_arready)
    |-> s_axi_rdata[31:7] == 25'h000_0000)
    else $error("address top bit not zero");
  // Hardware-owned clears and the self-timed length, counted from the start edge
  localparam int PROG_LEN = int'(NSP_PROG_CYC);
  a_erase_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    finish && is_erase_ff |=> !ctrl_ff[NSP_BIT_ERASE])
    else $error("erase bit not cleared by hardware");
  a_busy_len: assert property (@(posedge aclk) disable iff (!aresetn)
    start_op && !latch_only |-> ##[PROG_LEN:PROG_LEN] finish)
    else $error("timed operation length wrong");
  a_write_held: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == NSP_BUSY && !finish |=> ctrl_ff[NSP_BIT_WRITE])
    else $error("write bit dropped while busy");
  a_latch_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    start_op && latch_only |=> state_ff == NSP_IDLE && !ctrl_ff[NSP_BIT_WRITE])
    else $error("latch load started a program cycle");
  // Unimplemented data high bits must never leak onto the bus
  a_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_araddr) == NSP_OFS_DATA_HIGH && $past(s_axi_arready)
    |-> s_axi_rdata[31:6] == 26'h000_0000)
    else $error("data high upper bits not zero");
  // Second key without a first one must not unlock
  a_key_order: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_key && !key_armed_ff |=> !unlocked_ff)
    else $error("unlocked without first key");
endmodule // nsp_ctrl

// [design/nsp_pkg.sv]
package nsp_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [4:0] NSP_OFS_DATA_LOW = 5'h00;
  localparam logic [4:0] NSP_OFS_DATA_HIGH = 5'h04;
  localparam logic [4:0] NSP_OFS_ADDR_LOW = 5'h08;
  localparam logic [4:0] NSP_OFS_ADDR_HIGH = 5'h0c;
  localparam logic [4:0] NSP_OFS_CONTROL = 5'h10;
  localparam logic [4:0] NSP_OFS_UNLOCK = 5'h14;
  localparam logic [4:0] NSP_OFS_EVENT = 5'h18;
  // Control register field positions
  localparam int NSP_BIT_MEMSEL = 7;
  localparam int NSP_BIT_CFGSEL = 6;
  localparam int NSP_BIT_LATCH = 5;
  localparam int NSP_BIT_ERASE = 4;
  localparam int NSP_BIT_ERR = 3;
  localparam int NSP_BIT_PGMEN = 2;
  localparam int NSP_BIT_WRITE = 1;
  localparam int NSP_BIT_READ = 0;
  // Reset values and unlock key bytes
  localparam logic [7:0] NSP_RST_BYTE = 8'h00;
  localparam logic [5:0] NSP_RST_HIGH6 = 6'h00;
  localparam logic [6:0] NSP_RST_ADDR7 = 7'h00;
  localparam logic [7:0] NSP_KEY_FIRST = 8'h55;
  localparam logic [7:0] NSP_KEY_SECOND = 8'haa;
  // Configuration space map
  localparam logic [14:0] NSP_CFG_UID_LO = 15'h0000;
  localparam logic [14:0] NSP_CFG_UID_HI = 15'h0003;
  localparam logic [14:0] NSP_CFG_DEVID = 15'h0006;
  localparam logic [14:0] NSP_CFG_WORD_LO = 15'h0007;
  localparam logic [14:0] NSP_CFG_WORD_HI = 15'h0008;
  // Device identity word, value is arbitrary
  localparam logic [13:0] NSP_DEVICE_ID = 14'h0123;
  // Self-timed program or erase time in us and cycles at 40 MHz
  localparam int NSP_CLK_MHZ = 40;
  localparam int NSP_PROG_US = 2;
  localparam logic [7:0] NSP_PROG_CYC = 8'(NSP_PROG_US * NSP_CLK_MHZ);
  localparam logic [1:0] NSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] NSP_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {NSP_IDLE, NSP_BUSY} nsp_state_e;
endpackage

// [tb/nvm_self_program_control_bench.sv]
`timescale 1ns/10ps
module nvm_self_program_control_bench;
  import nsp_pkg::*;
  logic aclk, aresetn, cpu_stall, nvm_done_pulse;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int num_errors, total_checks, stall_cycles, n;

  nsp_ctrl nsp_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_stall(cpu_stall), .nvm_done_pulse(nvm_done_pulse));

  // 40 MHz core clock
  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master; waits an edge first so no signal is assigned twice in one step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (k == 100) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic rdr(input logic [4:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (k == 100) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask

  task automatic unlock;
    wr(NSP_OFS_UNLOCK, NSP_KEY_FIRST);
    wr(NSP_OFS_UNLOCK, NSP_KEY_SECOND);
  endtask

  // Counts edges until the completion pulse, also counting stalled cycles
  task automatic wait_done(input int lim);
    stall_cycles = 0;
    for (n = 0; n < lim; n++) begin
      @(posedge aclk);
      if (cpu_stall === 1'b1) stall_cycles++;
      if (nvm_done_pulse === 1'b1) break;
    end
    // A wait long enough for a whole operation must end with the pulse
    if (lim > int'(NSP_PROG_CYC) && n == lim) begin
      num_errors++;
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_map;
    rdchk(NSP_OFS_ADDR_LOW, 32'h0000_0000);
    rdchk(NSP_OFS_ADDR_HIGH, 32'h0000_0000);
    rdchk(NSP_OFS_CONTROL, 32'h0000_0000);
    wr(NSP_OFS_UNLOCK, NSP_KEY_FIRST);
    rdchk(NSP_OFS_UNLOCK, 32'h0000_0000);
    chk({30'h0, rs}, {30'h0, NSP_RESP_OKAY});
    rdchk(5'h1c, 32'h0000_0000);
    chk({30'h0, rs}, {30'h0, NSP_RESP_SLVERR});
    wr(5'h1c, 8'h12);
    chk({30'h0, rs}, {30'h0, NSP_RESP_SLVERR});
    wr(NSP_OFS_DATA_LOW, 8'ha5);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_00a5);
    s_axi_wstrb <= 4'h2;
    wr(NSP_OFS_DATA_LOW, 8'h5a);
    s_axi_wstrb <= 4'h1;
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_00a5);
    wr(NSP_OFS_DATA_HIGH, 8'hff);
    rdchk(NSP_OFS_DATA_HIGH, 32'h0000_003f);
    wr(NSP_OFS_ADDR_HIGH, 8'hff);
    rdchk(NSP_OFS_ADDR_HIGH, 32'h0000_007f);
    wr(NSP_OFS_ADDR_HIGH, 8'h00);
  endtask

  // Data byte write with latch-only and erase set, both to be ignored
  task automatic t_eeprom_write;
    wr(NSP_OFS_ADDR_LOW, 8'h21);
    wr(NSP_OFS_DATA_LOW, 8'h3c);
    wr(NSP_OFS_CONTROL, 8'h34);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h36);
    wait_done(300);
    chk(32'((n >= int'(NSP_PROG_CYC) - 6) && (n <= int'(NSP_PROG_CYC))), 32'h1);
    chk(32'(stall_cycles), 32'h0000_0000);
    rdr(NSP_OFS_CONTROL);
    chk(rd & 32'h0000_000e, 32'h0000_0004);
    rdchk(NSP_OFS_EVENT, 32'h0000_0001);
    wr(NSP_OFS_EVENT, 8'h01);
    rdchk(NSP_OFS_EVENT, 32'h0000_0000);
    wr(NSP_OFS_DATA_LOW, 8'h00);
    wr(NSP_OFS_CONTROL, 8'h05);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_003c);
    rdchk(NSP_OFS_CONTROL, 32'h0000_0004);
  endtask

  // Keys split by another write, then enable clear: both must be refused
  task automatic t_refused;
    wr(NSP_OFS_UNLOCK, NSP_KEY_FIRST);
    wr(NSP_OFS_DATA_LOW, 8'h77);
    wr(NSP_OFS_UNLOCK, NSP_KEY_SECOND);
    wr(NSP_OFS_CONTROL, 8'h06);
    wait_done(20);
    chk(32'(n), 32'd20);
    rdchk(NSP_OFS_CONTROL, 32'h0000_000c);
    wr(NSP_OFS_CONTROL, 8'h00);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h02);
    wait_done(20);
    chk(32'(n), 32'd20);
    rdchk(NSP_OFS_CONTROL, 32'h0000_0008);
    wr(NSP_OFS_CONTROL, 8'h01);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_003c);
  endtask

  // Flash word program, latch-only load, then a row erase
  task automatic t_flash;
    wr(NSP_OFS_ADDR_LOW, 8'h10);
    wr(NSP_OFS_DATA_LOW, 8'h34);
    wr(NSP_OFS_DATA_HIGH, 8'h12);
    wr(NSP_OFS_CONTROL, 8'h84);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h86);
    wait_done(300);
    chk(32'(n < 300), 32'h1);
    chk(32'(stall_cycles >= n), 32'h1);
    wr(NSP_OFS_DATA_LOW, 8'h00);
    wr(NSP_OFS_DATA_HIGH, 8'h00);
    wr(NSP_OFS_CONTROL, 8'h85);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_0034);
    rdchk(NSP_OFS_DATA_HIGH, 32'h0000_0012);
    wr(NSP_OFS_CONTROL, 8'ha4);
    unlock();
    wr(NSP_OFS_CONTROL, 8'ha6);
    wait_done(20);
    chk(32'(n), 32'd20);
    rdchk(NSP_OFS_CONTROL, 32'h0000_00a4);
    wr(NSP_OFS_CONTROL, 8'h94);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h96);
    wait_done(300);
    chk(32'(n < 300), 32'h1);
    rdchk(NSP_OFS_CONTROL, 32'h0000_0084);
    wr(NSP_OFS_CONTROL, 8'h85);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_00ff);
    rdchk(NSP_OFS_DATA_HIGH, 32'h0000_003f);
  endtask

  // Identity read, hole read, and a refused write to the identity word
  task automatic t_config;
    wr(NSP_OFS_ADDR_LOW, 8'h06);
    wr(NSP_OFS_CONTROL, 8'h41);
    rdchk(NSP_OFS_DATA_LOW, {24'h00_0000, NSP_DEVICE_ID[7:0]});
    rdchk(NSP_OFS_DATA_HIGH, {26'h000_0000, NSP_DEVICE_ID[13:8]});
    wr(NSP_OFS_ADDR_LOW, 8'h05);
    wr(NSP_OFS_CONTROL, 8'h41);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_0000);
    rdchk(NSP_OFS_DATA_HIGH, 32'h0000_0000);
    wr(NSP_OFS_ADDR_LOW, 8'h06);
    wr(NSP_OFS_CONTROL, 8'h44);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h46);
    wait_done(20);
    chk(32'(n), 32'd20);
    rdchk(NSP_OFS_CONTROL, 32'h0000_004c);
    wr(NSP_OFS_ADDR_LOW, 8'h01);
    wr(NSP_OFS_DATA_LOW, 8'h5a);
    wr(NSP_OFS_DATA_HIGH, 8'h2b);
    wr(NSP_OFS_CONTROL, 8'h44);
    unlock();
    wr(NSP_OFS_CONTROL, 8'h46);
    wait_done(300);
    chk(32'(stall_cycles >= n), 32'h1);
    wr(NSP_OFS_DATA_LOW, 8'h00);
    wr(NSP_OFS_DATA_HIGH, 8'h00);
    wr(NSP_OFS_CONTROL, 8'h41);
    rdchk(NSP_OFS_DATA_LOW, 32'h0000_005a);
    rdchk(NSP_OFS_DATA_HIGH, 32'h0000_002b);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: all inputs defined at time zero, reset for two cycles
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_eeprom_write();
    t_refused();
    t_flash();
    t_config();
    summarize();
  end
endmodule // nvm_self_program_control_bench
